// File: bfra_consts.svh
// constants for the byte file register alu datapath
`ifndef BFRA_CONSTS_SVH
`define BFRA_CONSTS_SVH
`define BFRA_LIT_OFS_MAX 8'h5F
`define BFRA_ACCESS_SPLIT 8'h80
`define BFRA_ACCESS_HI_BANK 4'hF
`define BFRA_DEST_ACC 1'b0
`define BFRA_DEST_FILE 1'b1
`define BFRA_BANK_ACCESS 1'b0
`define BFRA_BANK_BSR 1'b1
`define BFRA_ACC_RST 8'h00
`define BFRA_STAT_RST 5'h00
`define BFRA_FLAG_C 0
`define BFRA_FLAG_DC 1
`define BFRA_FLAG_Z 2
`define BFRA_FLAG_OV 3
`define BFRA_FLAG_N 4
`define BFRA_DATA_W 8
`define BFRA_NIBBLE_W 4
`define BFRA_SIGN_BIT 7
`endif

// File: bfra_pkg.sv
// types for the byte file register alu datapath
package bfra_pkg;
  typedef enum logic [1:0] {
    bfra_op_none = 2'b00,
    bfra_op_sub_borrow = 2'b01,
    bfra_op_swap = 2'b10
  } bfra_op_e;
  typedef enum logic [1:0] {
    bfra_mode_access = 2'b00,
    bfra_mode_banked = 2'b01,
    bfra_mode_indexed = 2'b10
  } bfra_mode_e;
endpackage

// File: bfra_addr_gen.sv
// operand address resolution for file register access
`include "bfra_consts.svh"
module bfra_addr_gen import bfra_pkg::*; (
  // instruction fields
  input wire logic [7:0] file_addr,
  input wire logic bank_access,
  input wire logic ext_set_en,
  // core state
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] index_base,
  // resolved address
  output logic [11:0] data_addr,
  output bfra_mode_e addr_mode
);
  always_comb begin
    if (bank_access == `BFRA_BANK_BSR) begin
      // [RULE5] bank plus offset
      addr_mode = bfra_mode_banked;
      data_addr = {bank_select_reg, file_addr};
    end else if (ext_set_en && file_addr <= `BFRA_LIT_OFS_MAX) begin
      // [RULE6] indexed literal offset
      addr_mode = bfra_mode_indexed;
      data_addr = index_base + {4'h0, file_addr};
    end else begin
      // [RULE4] access bank split
      addr_mode = bfra_mode_access;
      if (file_addr < `BFRA_ACCESS_SPLIT) begin
        data_addr = {4'h0, file_addr};
      end else begin
        data_addr = {`BFRA_ACCESS_HI_BANK, file_addr};
      end
    end
  end
endmodule

// File: bfra_alu.sv
// byte file register alu: subtract with borrow and nibble swap
//
// Overview of operation
// [RULE1] subtract-with-borrow gives file minus accumulator minus inverted carry.
// [RULE2] destination bit zero writes result to accumulator, file untouched.
// [RULE3] destination bit one writes result back to the file register.
// [RULE4] bank bit zero resolves the address inside the access bank.
// [RULE5] bank bit one joins bank select register with the file address.
// [RULE6] extended set, bank bit zero, address up to 5Fh: indexed offset.
// [RULE7] nibble swap puts low nibble high and high nibble low.
// [RULE8] subtract updates N OV C DC Z; swap leaves flags alone.
`include "bfra_consts.svh"
module bfra_alu import bfra_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // instruction from decoder
  input wire logic op_valid,
  input wire bfra_op_e op_code,
  input wire logic [7:0] file_addr,
  input wire logic dest_sel,
  input wire logic bank_access,
  input wire logic ext_set_en,
  // core state
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] index_base,
  // register file read and write
  output logic [11:0] rf_addr,
  input wire logic [7:0] rf_rdata,
  output logic rf_we,
  output logic [7:0] rf_wdata,
  // accumulator and status
  output logic [7:0] acc,
  output logic [4:0] status_flags,
  output bfra_mode_e addr_mode
);
  // decoded operation strobes
  logic do_sub;
  logic do_swap;
  logic do_op;

  // subtractor: f plus inverted w plus carry
  logic [7:0] sub_a;
  logic [7:0] sub_b;
  wire logic [8:0] chain;
  wire logic [7:0] sub_sum;

  // flag candidates taken from the subtractor
  logic flag_c;
  logic flag_dc;
  logic flag_z;
  logic flag_ov;
  logic flag_n;

  // nibble exchange of the source byte
  wire logic [7:0] swap_byte;

  // chosen result and destination
  logic [7:0] result;
  logic to_acc;
  logic to_file;

  // next register values
  logic [7:0] next_acc;
  logic [4:0] next_status;

  genvar bi;

  bfra_addr_gen u_addr (
    .file_addr(file_addr),
    .bank_access(bank_access),
    .ext_set_en(ext_set_en),
    .bank_select_reg(bank_select_reg),
    .index_base(index_base),
    .data_addr(rf_addr),
    .addr_mode(addr_mode)
  );

  // an unused code is refused: no write and no flag change
  always_comb begin
    do_sub = 1'b0;
    do_swap = 1'b0;
    unique case (op_code)
      bfra_op_none: begin
        do_swap = 1'b0;
      end
      bfra_op_sub_borrow: begin
        do_sub = op_valid;
      end
      bfra_op_swap: begin
        do_swap = op_valid;
      end
      default: begin
        do_sub = 1'b0;
      end
    endcase
  end

  assign do_op = do_sub || do_swap;

  // [RULE1] operands for f minus w minus inverted carry
  assign sub_a = rf_rdata;
  assign sub_b = ~acc;
  // carry set means no borrow, so it enters the chain as it stands
  assign chain[0] = status_flags[`BFRA_FLAG_C];

  // [RULE1] ripple chain, bit 3 carry kept for the digit flag
  generate
    for (bi = 0; bi < `BFRA_DATA_W; bi++) begin : g_sub
      assign sub_sum[bi] = sub_a[bi] ^ sub_b[bi] ^ chain[bi];
      assign chain[bi + 1] = (sub_a[bi] & sub_b[bi])
        | (chain[bi] & (sub_a[bi] ^ sub_b[bi]));
    end
  endgenerate

  // [RULE8] flag candidates
  always_comb begin
    flag_c = chain[`BFRA_DATA_W];
    flag_dc = chain[`BFRA_NIBBLE_W];
    flag_z = (sub_sum == 8'h00);
    flag_n = sub_sum[`BFRA_SIGN_BIT];
    // carry into the sign bit differing from the carry out is overflow
    flag_ov = chain[`BFRA_DATA_W] ^ chain[`BFRA_SIGN_BIT];
  end

  // [RULE7] nibble exchange
  generate
    for (bi = 0; bi < `BFRA_NIBBLE_W; bi++) begin : g_swap
      assign swap_byte[bi + `BFRA_NIBBLE_W] = rf_rdata[bi];
      assign swap_byte[bi] = rf_rdata[bi + `BFRA_NIBBLE_W];
    end
  endgenerate

  // result of the current operation, the source byte when idle
  always_comb begin
    result = rf_rdata;
    if (do_sub) begin
      result = sub_sum;
    end else if (do_swap) begin
      result = swap_byte;
    end
  end

  // destination choice from the d bit
  always_comb begin
    to_acc = 1'b0;
    to_file = 1'b0;
    if (do_op) begin
      if (dest_sel == `BFRA_DEST_ACC) begin
        // [RULE2] result to accumulator
        to_acc = 1'b1;
      end else begin
        // [RULE3] result back to file
        to_file = 1'b1;
      end
    end
  end

  // strobe and data stay combinational so a read-modify-write fits in
  // one cycle; the file must latch them on the coming edge
  assign rf_we = to_file;
  assign rf_wdata = result;

  // [RULE2] accumulator only moves when it is the destination
  always_comb begin
    next_acc = acc;
    if (to_acc) begin
      next_acc = result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc <= `BFRA_ACC_RST;
    end else begin
      acc <= next_acc;
    end
  end

  // [RULE8] subtract loads every flag, swap keeps them
  always_comb begin
    next_status = status_flags;
    if (do_sub) begin
      next_status[`BFRA_FLAG_C] = flag_c;
      next_status[`BFRA_FLAG_DC] = flag_dc;
      next_status[`BFRA_FLAG_Z] = flag_z;
      next_status[`BFRA_FLAG_OV] = flag_ov;
      next_status[`BFRA_FLAG_N] = flag_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_flags <= `BFRA_STAT_RST;
    end else begin
      status_flags <= next_status;
    end
  end
endmodule

// File: bfra_alu_sva.sv
// checker for the byte file register alu ports
`include "bfra_consts.svh"
module bfra_alu_sva import bfra_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // instruction
  input wire logic op_valid,
  input wire bfra_op_e op_code,
  input wire logic [7:0] file_addr,
  input wire logic dest_sel,
  input wire logic bank_access,
  input wire logic ext_set_en,
  // core state and read data
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] index_base,
  input wire logic [7:0] rf_rdata,
  // results
  input wire logic [11:0] rf_addr,
  input wire logic rf_we,
  input wire logic [7:0] rf_wdata,
  input wire logic [7:0] acc,
  input wire logic [4:0] status_flags,
  input wire bfra_mode_e addr_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dif, res;
  logic sb, sw, ix;
  assign dif = rf_rdata - acc - {7'h00, ~status_flags[`BFRA_FLAG_C]};
  assign sb = op_valid && op_code == bfra_op_sub_borrow;
  assign sw = op_valid && op_code == bfra_op_swap;
  assign res = sb ? dif : {rf_rdata[3:0], rf_rdata[7:4]};
  assign ix = ext_set_en && !bank_access && file_addr <= `BFRA_LIT_OFS_MAX;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_sub; sb && dest_sel |-> rf_wdata == dif; endproperty
  property p_acc; (sb || sw) && !dest_sel |-> !rf_we ##1 acc == $past(res);
  endproperty
  property p_fil; (sb || sw) && dest_sel |-> rf_we && rf_wdata == res;
  endproperty
  property p_acs; !bank_access && !ix |-> addr_mode == bfra_mode_access &&
    rf_addr == {{4{file_addr[7]}}, file_addr}; endproperty
  property p_bnk; bank_access |-> rf_addr == {bank_select_reg, file_addr};
  endproperty
  property p_idx; ix |-> addr_mode == bfra_mode_indexed &&
    rf_addr == index_base + file_addr; endproperty
  property p_swp; sw |-> rf_wdata == {rf_rdata[3:0], rf_rdata[7:4]};
  endproperty
  property p_kep; sw |=> $stable(status_flags); endproperty
  property p_zer;
    sb |=> status_flags[`BFRA_FLAG_Z] == ($past(dif) == 8'h00);
  endproperty
  a_sub: assert property (p_sub) else $error("sub result wrong");
  a_acc: assert property (p_acc) else $error("acc dest wrong");
  a_fil: assert property (p_fil) else $error("file dest wrong");
  a_acs: assert property (p_acs) else $error("access addr wrong");
  a_bnk: assert property (p_bnk) else $error("banked addr wrong");
  a_idx: assert property (p_idx) else $error("indexed addr wrong");
  a_swp: assert property (p_swp) else $error("swap wrong");
  a_kep: assert property (p_kep) else $error("swap moved flags");
  a_zer: assert property (p_zer) else $error("zero flag wrong");
  c_sub: cover property (sb && dest_sel);
  c_swp: cover property (sw && !dest_sel);
  c_idx: cover property (ix);
endmodule
bind bfra_alu bfra_alu_sva u_sva (.clk_sys, .rst, .op_valid, .dest_sel,
  .bank_access, .ext_set_en, .op_code, .file_addr, .rf_rdata, .rf_wdata,
  .acc, .bank_select_reg, .index_base, .rf_addr, .rf_we, .status_flags,
  .addr_mode);

// File: tb_bfra_alu.sv
// testbench for the byte file register alu
module tb_bfra_alu import bfra_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, op_valid = 0, dest_sel = 0, bank_access = 0;
  logic ext_set_en = 0, rf_we;
  bfra_op_e op_code = bfra_op_none;
  bfra_mode_e addr_mode;
  logic [7:0] file_addr = 0, rf_rdata = 0, rf_wdata, acc;
  logic [3:0] bank_select_reg = 4'h5;
  logic [11:0] index_base = 12'h100, rf_addr;
  logic [4:0] status_flags;
  int fails = 0, comparisons = 0, cyc = 0;
  bfra_alu DUT (.clk_sys, .rst, .op_valid, .op_code, .file_addr, .dest_sel,
    .bank_access, .ext_set_en, .bank_select_reg, .index_base, .rf_addr,
    .rf_rdata, .rf_we, .rf_wdata, .acc, .status_flags, .addr_mode);
  always #25 clk_sys = ~clk_sys;
  task stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      stop_test;
    end
  end
  task chk(input logic [11:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t saw %h want %h", $time, s, e);
    end
  endtask
  task op(input bfra_op_e c, input logic [7:0] f, r, input logic d);
    @(negedge clk_sys);
    op_code = c;
    file_addr = f;
    rf_rdata = r;
    dest_sel = d;
    #5;
  endtask
  task adr(input logic a, x, input logic [7:0] f);
    @(negedge clk_sys);
    op_code = bfra_op_none;
    bank_access = a;
    ext_set_en = x;
    file_addr = f;
    #5;
  endtask
  task vld(input logic v);
    @(negedge clk_sys);
    op_valid = v;
  endtask
  task t_alu;
    op(bfra_op_sub_borrow, 8'h10, 8'h0E, 1'h0);
    chk(rf_we, 1'h0);
    op(bfra_op_sub_borrow, 8'h10, 8'h19, 1'h1);
    chk(acc, 8'h0D);
    chk(rf_wdata, 8'h0C);
    chk(rf_we, 1'h1);
    op(bfra_op_sub_borrow, 8'h10, 8'h0D, 1'h1);
    chk(status_flags[2:0], 3'h1);
    op(bfra_op_sub_borrow, 8'h10, 8'h03, 1'h1);
    chk(status_flags[2:0], 3'h7);
    chk(rf_wdata, 8'hF6);
    op(bfra_op_swap, 8'h10, 8'h53, 1'h1);
    chk(status_flags, 5'h10);
    chk(rf_wdata, 8'h35);
    op(bfra_op_swap, 8'h10, 8'hC2, 1'h0);
    chk(rf_we, 1'h0);
    op(bfra_op_none, 8'h10, 8'h00, 1'h1);
    chk(acc, 8'h2C);
    chk(status_flags, 5'h10);
  endtask
  // 80h minus 01h minus borrow crosses the sign; then op_valid low
  task t_ovf;
    op(bfra_op_swap, 8'h10, 8'h10, 1'h0);
    op(bfra_op_sub_borrow, 8'h10, 8'h80, 1'h1);
    chk(acc, 8'h01);
    chk(rf_wdata, 8'h7E);
    op(bfra_op_none, 8'h10, 8'h00, 1'h1);
    chk(status_flags, 5'h09);
    vld(1'h0);
    op(bfra_op_sub_borrow, 8'h10, 8'h0E, 1'h1);
    chk(rf_we, 1'h0);
    op(bfra_op_sub_borrow, 8'h10, 8'h0E, 1'h0);
    op(bfra_op_none, 8'h10, 8'h00, 1'h1);
    chk(acc, 8'h01);
    chk(status_flags, 5'h09);
    vld(1'h1);
  endtask
  // a reset in mid-run must clear a non-zero accumulator and flags
  task t_rst;
    @(negedge clk_sys);
    rst = 1'h1;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    chk(acc, 8'h00);
    chk(status_flags, 5'h00);
  endtask
  task t_addr;
    adr(1'h1, 1'h0, 8'hA3);
    chk(rf_addr, 12'h5A3);
    chk(addr_mode, bfra_mode_banked);
    adr(1'h1, 1'h1, 8'h20);
    chk(rf_addr, 12'h520);
    adr(1'h0, 1'h0, 8'hA3);
    chk(rf_addr, 12'hFA3);
    chk(addr_mode, bfra_mode_access);
    adr(1'h0, 1'h0, 8'h23);
    chk(rf_addr, 12'h023);
    adr(1'h0, 1'h1, 8'h5F);
    chk(rf_addr, 12'h15F);
    chk(addr_mode, bfra_mode_indexed);
    adr(1'h0, 1'h1, 8'h60);
    chk(rf_addr, 12'h060);
    chk(addr_mode, bfra_mode_access);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 0;
    op_valid = 1;
    chk(acc, 8'h00);
    chk(status_flags, 5'h00);
    t_alu;
    t_ovf;
    t_rst;
    t_addr;
    stop_test;
  end
endmodule
